// File: tas_pkg.sv
// Constants for the thermal alarm status and mask block
package tas_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ALARM_STATUS_ADDR = 8'h02;
   localparam logic [7:0] ALARM_MASK_ADDR = 8'h16;
   // ---------------------------------------------------------------
   // Status field positions
   // ---------------------------------------------------------------
   localparam int BIT_BUSY = 7;
   localparam int BIT_LOCAL_HIGH = 6;
   localparam int BIT_UNUSED5 = 5;
   localparam int BIT_REMOTE_HIGH = 4;
   localparam int BIT_REMOTE_LOW = 3;
   localparam int BIT_DIODE_FAULT = 2;
   localparam int BIT_REMOTE_CRIT = 1;
   localparam int BIT_TACH_LOW = 0;
   // ---------------------------------------------------------------
   // Field groups and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] STATUS_LATCH_BITS = 8'h5F;
   localparam logic [7:0] NOTIFY_SRC_BITS = 8'h5B;
   localparam logic [7:0] MASK_RW_BITS = 8'h5B;
   localparam logic [7:0] MASK_ONES_BITS = 8'hA4;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : tas_pkg

// File: tas_alarm.sv
// Alarm status latch, mask register and notify pin driver

module tas_alarm (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic conv_busy,
   input wire logic cond_local_high,
   input wire logic cond_remote_high,
   input wire logic cond_remote_low,
   input wire logic cond_diode_fault,
   input wire logic cond_remote_crit,
   input wire logic cond_tach_low,
   input wire logic comparator_mode,
   output logic notify_out,
   output logic notify_oe
);

   // ---------------------------------------------------------------
   // Live conditions gathered into status layout
   // ---------------------------------------------------------------

   // Current alarm conditions, bits 7 and 5 always zero
   logic [7:0] cond_vec;
   // Latched alarm bits
   logic [7:0] status;
   // Next latched alarm bits
   logic [7:0] next_status;
   // Stored mask bits, unused positions held at zero
   logic [7:0] mask;
   // Next mask bits
   logic [7:0] next_mask;
   // Read data register and its strobe
   logic [7:0] next_rdata;
   logic next_rvalid;
   // Notify drive enable and its next value
   logic next_oe;
   // Decoded accesses
   logic rd_status;
   logic rd_mask;
   logic wr_mask;

   // Condition vector assembly
   always_comb begin
      cond_vec = 8'h00;
      cond_vec[tas_pkg::BIT_LOCAL_HIGH] = cond_local_high;
      cond_vec[tas_pkg::BIT_REMOTE_HIGH] = cond_remote_high;
      cond_vec[tas_pkg::BIT_REMOTE_LOW] = cond_remote_low;
      cond_vec[tas_pkg::BIT_DIODE_FAULT] = cond_diode_fault;
      cond_vec[tas_pkg::BIT_REMOTE_CRIT] = cond_remote_crit;
      cond_vec[tas_pkg::BIT_TACH_LOW] = cond_tach_low;
   end

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------

   // Strobes qualified by address
   always_comb begin
      rd_status = 1'b0;
      rd_mask = 1'b0;
      wr_mask = 1'b0;
      if (reg_addr == tas_pkg::ALARM_STATUS_ADDR) begin
         rd_status = reg_rd;
      end else if (reg_addr == tas_pkg::ALARM_MASK_ADDR) begin
         rd_mask = reg_rd;
         wr_mask = reg_wr;
      end
   end

   // ---------------------------------------------------------------
   // Status latch and mask
   // ---------------------------------------------------------------

   // Set wins over read clear, so an alarm never slips away
   always_comb begin
      next_status = status;
      if (rd_status) begin
         next_status = 8'h00;
      end
      next_status = (next_status | cond_vec)
         & tas_pkg::STATUS_LATCH_BITS;
      next_mask = mask;
      if (wr_mask) begin
         next_mask = reg_wdata & tas_pkg::MASK_RW_BITS;
      end
   end

   // Register status and mask
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         status <= tas_pkg::STATUS_RESET;
         mask <= tas_pkg::MASK_RESET;
      end else if (ce) begin
         status <= next_status;
         mask <= next_mask;
      end
   end

   // ---------------------------------------------------------------
   // Read data path
   // ---------------------------------------------------------------

   // Read returns value seen before any clear
   always_comb begin
      next_rdata = reg_rdata;
      next_rvalid = 1'b0;
      if (reg_rd) begin
         next_rvalid = 1'b1;
         if (rd_status) begin
            next_rdata = status;
            next_rdata[tas_pkg::BIT_BUSY] = conv_busy;
            next_rdata[tas_pkg::BIT_UNUSED5] = 1'b0;
         end else if (rd_mask) begin
            next_rdata = mask | tas_pkg::MASK_ONES_BITS;
         end else begin
            next_rdata = tas_pkg::UNMAPPED_READ;
         end
      end
   end

   // Register read data
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else if (ce) begin
         reg_rdata <= next_rdata;
         reg_rvalid <= next_rvalid;
      end
   end

   // ---------------------------------------------------------------
   // Notify pin
   // ---------------------------------------------------------------

   // Busy and diode fault are outside the notify source set
   always_comb begin
      if (comparator_mode) begin
         next_oe = |(cond_vec & ~mask & tas_pkg::NOTIFY_SRC_BITS);
      end else begin
         next_oe = |(status & ~mask & tas_pkg::NOTIFY_SRC_BITS);
      end
   end

   // Active-low open drain: drive low while enabled
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         notify_oe <= 1'b0;
         notify_out <= 1'b0;
      end else if (ce) begin
         notify_oe <= next_oe;
         notify_out <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------

   // One clock for every property; none runs in reset
   default clocking prop_clk @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // Latched bit persists without a read
   a_status_hold: assert property (
      ce && !rd_status && status[tas_pkg::BIT_REMOTE_HIGH]
      |=> status[tas_pkg::BIT_REMOTE_HIGH])
      else $error("latched alarm lost without read");

   // Read with condition gone clears the bit
   a_read_clear: assert property (
      ce && rd_status && !cond_tach_low
      |=> !status[tas_pkg::BIT_TACH_LOW])
      else $error("alarm not cleared by read");

   // Present condition survives a read
   a_read_keeps: assert property (
      ce && rd_status && cond_remote_crit
      |=> status[tas_pkg::BIT_REMOTE_CRIT])
      else $error("active alarm cleared by read");

   // Busy flag read back live
   a_busy_read: assert property (
      ce && rd_status
      |=> reg_rvalid && reg_rdata[7] == $past(conv_busy))
      else $error("busy bit wrong on read");

   // Unused status bit reads zero
   a_status_zero: assert property (
      ce && rd_status |=> reg_rdata[5] == 1'b0)
      else $error("status bit 5 not zero");

   // Unused mask bits read one
   a_mask_ones: assert property (
      ce && rd_mask |=> reg_rdata[7] && reg_rdata[5] && reg_rdata[2])
      else $error("mask unused bits not one");

   // Interrupt mode follows latched unmasked alarm
   a_irq_notify: assert property (
      ce && !comparator_mode && status[tas_pkg::BIT_LOCAL_HIGH]
      && !mask[tas_pkg::BIT_LOCAL_HIGH] |=> notify_oe)
      else $error("notify missing in interrupt mode");

   // Masked or fault only alarm stays quiet
   a_fault_quiet: assert property (
      ce && !comparator_mode
      && ((status & ~mask & tas_pkg::NOTIFY_SRC_BITS) == 8'h00)
      |=> !notify_oe)
      else $error("notify without unmasked alarm");

   // Busy alone never pulls the pin
   a_busy_quiet: assert property (
      ce && !comparator_mode && conv_busy
      && ((status & ~mask & tas_pkg::NOTIFY_SRC_BITS) == 8'h00)
      |=> !notify_oe)
      else $error("notify raised by busy flag");

   // Comparator mode tracks live condition
   a_cmp_notify: assert property (
      ce && comparator_mode && cond_remote_low
      && !mask[tas_pkg::BIT_REMOTE_LOW] |=> notify_oe)
      else $error("notify missing in comparator mode");

   // Comparator mode lets go once every cause is gone
   a_cmp_release: assert property (
      ce && comparator_mode && !cond_local_high && !cond_remote_high
      && !cond_remote_low && !cond_remote_crit && !cond_tach_low
      |=> !notify_oe)
      else $error("notify held without live cause");

   // Mask write takes effect
   a_mask_write: assert property (
      ce && wr_mask
      |=> mask == ($past(reg_wdata) & tas_pkg::MASK_RW_BITS))
      else $error("mask write not stored");

   // Mask keeps its value between writes
   a_mask_hold: assert property (
      ce && !wr_mask |=> mask == $past(mask))
      else $error("mask changed without write");

   // Local high cause latches its bit
   a_local_set: assert property (
      ce && cond_local_high |=> status[tas_pkg::BIT_LOCAL_HIGH])
      else $error("local high alarm not latched");

   // Remote high cause latches its bit
   a_remote_high_set: assert property (
      ce && cond_remote_high |=> status[tas_pkg::BIT_REMOTE_HIGH])
      else $error("remote high alarm not latched");

   // Remote low cause latches its bit
   a_remote_low_set: assert property (
      ce && cond_remote_low |=> status[tas_pkg::BIT_REMOTE_LOW])
      else $error("remote low alarm not latched");

   // Diode fault latches its bit
   a_diode_set: assert property (
      ce && cond_diode_fault |=> status[tas_pkg::BIT_DIODE_FAULT])
      else $error("diode fault not latched");

   // Slow fan latches its bit
   a_tach_set: assert property (
      ce && cond_tach_low |=> status[tas_pkg::BIT_TACH_LOW])
      else $error("tach alarm not latched");

   // Frozen enable keeps latched alarms and mask
   a_freeze_hold: assert property (
      !ce |=> status == $past(status) && mask == $past(mask))
      else $error("state moved while enable low");

   // ---------------------------------------------------------------
   // Cover points
   // ---------------------------------------------------------------

   // Interrupt mode pin released after a clearing read
   c_irq: cover property (!comparator_mode && notify_oe ##1 !notify_oe);

   // Comparator mode pin asserted
   c_cmp: cover property (comparator_mode && notify_oe);

   // Read clears every latched alarm when no cause is present
   c_clear: cover property (rd_status && |status ##1 status == 8'h00);

   // Latched alarm held back by its mask
   c_masked: cover property (
      |(status & mask & tas_pkg::NOTIFY_SRC_BITS) && !notify_oe);

endmodule : tas_alarm

// File: tas_host.sv
// Register host model for the status and mask port
module tas_host (
   input wire logic clock,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle lines at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // One write strobe; released lines show inverted values
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   // One read strobe, then a bounded wait for the data pulse
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      do begin
         @(posedge clock);
         n++;
      end while (!reg_rvalid && n < 4);
      q = reg_rvalid ? reg_rdata : 8'hxx;
   endtask : rd
endmodule : tas_host

// File: thermal_alarm_status_mask_tb.sv
// Self-checking bench for the alarm status and mask block
module thermal_alarm_status_mask_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1; // Clock enable, low only in the freeze test
   logic mode = 1'b0; // Comparator mode select
   logic [7:0] cnd = 8'h00; // Busy in bit 7, causes in status order
   logic [7:0] addr, wdata, rdata, q;
   logic wr, rd, rvalid, n_out, n_oe;
   int fail_count = 0;
   int comparisons = 0;
   int bits[5] = '{6, 4, 3, 1, 0}; // Alarms that notify
   localparam logic [7:0] SA = tas_pkg::ALARM_STATUS_ADDR;
   localparam logic [7:0] MA = tas_pkg::ALARM_MASK_ADDR;
   // ---------------------------------------------------------------
   // Clock, design and host
   // ---------------------------------------------------------------
   initial begin
      forever #4 clock = ~clock;
   end
   tas_alarm i_tas_alarm (.clock(clock), .rst_b(rst_b), .ce(ce),
      .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
      .reg_rdata(rdata), .reg_rvalid(rvalid), .conv_busy(cnd[7]),
      .cond_local_high(cnd[6]), .cond_remote_high(cnd[4]),
      .cond_remote_low(cnd[3]), .cond_diode_fault(cnd[2]),
      .cond_remote_crit(cnd[1]), .cond_tach_low(cnd[0]),
      .comparator_mode(mode), .notify_out(n_out), .notify_oe(n_oe));
   tas_host i_tas_host (.clock(clock), .reg_addr(addr), .reg_wr(wr),
      .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
      .reg_rvalid(rvalid));
   // ---------------------------------------------------------------
   // Compare, read-compare and pin-compare helpers
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen,
                      input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
      i_tas_host.rd(a, q);
      chk(nm, q, e);
   endtask : rdc
   task automatic tk(input int n, input logic e);
      repeat (n) @(posedge clock);
      chk("notify_oe", {7'h00, n_oe}, {7'h00, e});
      chk("notify_out", {7'h00, n_out}, 8'h00);
   endtask : tk
   task automatic final_report;
      if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      rdc(SA, 8'h00, "status reset");
      rdc(MA, 8'hA4, "mask reset");
      rdc(8'h03, 8'h00, "unmapped");
      i_tas_host.wr(SA, 8'hFF);
      rdc(SA, 8'h00, "status read only");
      i_tas_host.wr(MA, 8'hFF);
      rdc(MA, 8'hFF, "mask all");
      i_tas_host.wr(MA, 8'h00);
      rdc(MA, 8'hA4, "mask clear");
      // Each notifying alarm: latch, read-clear, then masked
      foreach (bits[i]) begin
         @(posedge clock);
         cnd <= 8'h01 << bits[i];
         tk(3, 1'b1);
         cnd <= 8'h00;
         rdc(SA, 8'h01 << bits[i], "alarm latched");
         rdc(SA, 8'h00, "alarm cleared");
         tk(2, 1'b0);
         i_tas_host.wr(MA, 8'h01 << bits[i]);
         cnd <= 8'h01 << bits[i];
         tk(3, 1'b0);
         cnd <= 8'h00;
         rdc(SA, 8'h01 << bits[i], "masked latched");
         i_tas_host.wr(MA, 8'h00);
      end
      // Busy and diode fault never notify; read while present
      cnd <= 8'h84;
      tk(3, 1'b0);
      rdc(SA, 8'h84, "busy fault");
      cnd <= 8'h00;
      rdc(SA, 8'h04, "fault held");
      rdc(SA, 8'h00, "fault cleared");
      // Comparator mode follows the live cause
      mode <= 1'b1;
      cnd <= 8'h10;
      tk(2, 1'b1);
      cnd <= 8'h00;
      tk(2, 1'b0);
      mode <= 1'b0;
      tk(2, 1'b1);
      rdc(SA, 8'h10, "comparator latch");
      // Frozen enable ignores a passing cause
      @(posedge clock);
      ce <= 1'b0;
      cnd <= 8'h40;
      repeat (3) @(posedge clock);
      cnd <= 8'h00;
      @(posedge clock);
      ce <= 1'b1;
      tk(2, 1'b0);
      rdc(SA, 8'h00, "frozen status");
      // Reset in mid-run returns the mask to its default
      i_tas_host.wr(MA, 8'h5B);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      rdc(MA, 8'hA4, "mask after reset");
      final_report();
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (4000) @(posedge clock);
      fail_count++;
      final_report();
   end
endmodule : thermal_alarm_status_mask_tb
